// ===== pixel_pipe_defines.vh
// Constants for the palette pixel pipeline
`ifndef PIXEL_PIPE_DEFINES_VH
`define PIXEL_PIPE_DEFINES_VH
`define MODE_HI 7
`define MODE_LO 4
`define MODE_PSEUDO8 4'h0
`define MODE_BYP15_B 4'h1
`define MODE_BYP16_B 4'h2
`define MODE_BYP24_B 4'h3
`define MODE_PSEUDO16 4'h4
`define MODE_BYP15_W 4'h5
`define MODE_BYP16_W 4'h6
`define MODE_BYP24_SP 4'h7
`define MODE_BYP24_PK 4'h8
`define CMD_RESET 8'h00
`define MASK_RESET 8'hFF
`define PIPE_DEPTH 3
`endif

// ===== palette_ram.v
// Palette memory with pixel read port and host write port
`timescale 1ns/1ns
module palette_ram
#(
	parameter ENTRIES = 256,
	parameter AW = 8,
	parameter DW = 18
)
(
	input wire sys_clk,
	input wire wr_en,
	input wire [AW-1:0] wr_addr,
	input wire [DW-1:0] wr_data,
	input wire [AW-1:0] rd_addr,
	output reg [DW-1:0] rd_data
);
	// Colour entries
	reg [DW-1:0] mem [0:ENTRIES-1];

	// Registered read, host write
	always @(posedge sys_clk)
	begin
		if (wr_en)
			mem[wr_addr] <= wr_data;
		rd_data <= mem[rd_addr];
	end
endmodule // palette_ram

// ===== palette_pixel_pipeline.v
// Pixel pipeline: masking, palette lookup, bypass, blank and sense
`timescale 1ns/1ns
`include "pixel_pipe_defines.vh"
module palette_pixel_pipeline
#(
	parameter ENTRIES = 256,
	parameter AW = 8,
	parameter CW = 6,
	parameter DACW = 8
)
(
	input wire sys_clk,
	input wire reset,
	input wire [15:0] pixel_bus,
	input wire blank_n,
	input wire [7:0] command,
	input wire [7:0] pixel_mask,
	input wire pal_wr_en,
	input wire [AW-1:0] pal_wr_addr,
	input wire [3*CW-1:0] pal_wr_data,
	input wire [2:0] comp_above,
	output reg [DACW-1:0] dac_red,
	output reg [DACW-1:0] dac_green,
	output reg [DACW-1:0] dac_blue,
	output reg dac_power_down,
	output reg sense_n,
	output reg [3:0] video_mode
);
	// Scale a narrow colour field to the DAC width by bit repeat
	function [DACW-1:0] widen;
		input [7:0] v;
		input [3:0] w;
		reg [15:0] t;
		begin
			// Field at the top, its own upper bits repeated below it
			t = {8'h00, v} << (5'h10 - {1'b0, w});
			t = t | ({8'h00, v} << (5'h10 - {w, 1'b0}));
			widen = t[15:16-DACW];
		end
	endfunction

	// Pin synchronisers, two stages
	reg [15:0] pix_s1;
	reg [15:0] pix_s2;
	reg blank_s1;
	reg blank_s2;
	reg [7:0] cmd_s1;
	reg [7:0] cmd_s2;
	reg [7:0] mask_s1;
	reg [7:0] mask_s2;
	reg [2:0] comp_s1;
	reg [2:0] comp_s2;
	// Previous blank, for rising edge
	reg blank_prev;
	// Word phase toggles byte/word halves
	reg phase;
	// Held first half of a split pixel
	reg [15:0] held;
	// 24-bit counter: bytes in 24-bit byte mode, words in packed mode
	reg [1:0] pk_cnt;
	// Stage one: index and bypass colour
	reg [AW-1:0] index1;
	reg [23:0] byp1;
	reg byp_sel1;
	reg blank1;
	// Stage two aligned with palette read
	reg [23:0] byp2;
	reg byp_sel2;
	reg blank2;
	// Palette read data
	wire [3*CW-1:0] pal_q;
	// Assembled bypass colour this cycle
	reg [23:0] next_byp;
	reg next_valid;
	reg [AW-1:0] next_index;
	wire blank_rise;
	wire [3:0] mode;
	// Frame position of the word in the last sync stage
	wire cur_phase;
	wire [1:0] cur_cnt;

	assign blank_rise = blank_s2 & ~blank_prev;
	// word at the blank rise opens a frame
	assign cur_phase = blank_rise ? 1'b0 : phase;
	assign cur_cnt = blank_rise ? 2'h0 : pk_cnt;
	assign mode = cmd_s2[`MODE_HI:`MODE_LO];

	// Synchronise pixel, blank, command, mask and comparator inputs; palette write port is not synchronised
	always @(posedge sys_clk)
	begin
		if (reset)
		begin
			pix_s1 <= 16'h0000;
			pix_s2 <= 16'h0000;
			blank_s1 <= 1'b0;
			blank_s2 <= 1'b0;
			cmd_s1 <= `CMD_RESET;
			cmd_s2 <= `CMD_RESET;
			mask_s1 <= `MASK_RESET;
			mask_s2 <= `MASK_RESET;
			comp_s1 <= 3'h0;
			comp_s2 <= 3'h0;
		end
		else
		begin
			pix_s1 <= pixel_bus;
			pix_s2 <= pix_s1;
			blank_s1 <= blank_n;
			blank_s2 <= blank_s1;
			cmd_s1 <= command;
			cmd_s2 <= cmd_s1;
			mask_s1 <= pixel_mask;
			mask_s2 <= mask_s1;
			comp_s1 <= comp_above;
			comp_s2 <= comp_s1;
		end
	end

	// Assemble bypass colour and pseudo index per mode
	always @*
	begin
		next_byp = byp1;
		next_valid = 1'b1;
		next_index = pix_s2[7:0] & mask_s2;
		// pseudo-colour, bypass, sparse and packed modes
		case (mode)
			`MODE_PSEUDO8:
				next_valid = 1'b1;
			`MODE_PSEUDO16:
			begin
				if (cur_phase)
					next_index = pix_s2[15:8] & mask_s2;
				else
					next_index = pix_s2[7:0] & mask_s2;
			end
			// byte modes use low byte only
			`MODE_BYP15_B, `MODE_BYP16_B:
			begin
				next_valid = cur_phase;
				if (mode == `MODE_BYP15_B)
					next_byp = {widen({3'h0, pix_s2[6:2]}, 4'd5),
						widen({3'h0, pix_s2[1:0], held[7:5]}, 4'd5),
						widen({3'h0, held[4:0]}, 4'd5)};
				else
					next_byp = {widen({3'h0, pix_s2[7:3]}, 4'd5),
						widen({2'h0, pix_s2[2:0], held[7:5]}, 4'd6),
						widen({3'h0, held[4:0]}, 4'd5)};
			end
			`MODE_BYP24_B:
			begin
				next_valid = (cur_cnt == 2'd2);
				next_byp = {pix_s2[7:0], held[15:8], held[7:0]};
			end
			`MODE_BYP15_W:
				next_byp = {widen({3'h0, pix_s2[14:10]}, 4'd5),
					widen({3'h0, pix_s2[9:5]}, 4'd5),
					widen({3'h0, pix_s2[4:0]}, 4'd5)};
			`MODE_BYP16_W:
				next_byp = {widen({3'h0, pix_s2[15:11]}, 4'd5),
					widen({2'h0, pix_s2[10:5]}, 4'd6),
					widen({3'h0, pix_s2[4:0]}, 4'd5)};
			`MODE_BYP24_SP:
			begin
				// Sparse: two words per pixel, top byte unused
				next_valid = cur_phase;
				next_byp = {pix_s2[7:0], held[15:0]};
			end
			`MODE_BYP24_PK:
			begin
				// Packed: three words carry two pixels
				next_valid = (cur_cnt != 2'd0);
				if (cur_cnt == 2'd1)
					next_byp = {pix_s2[7:0], held[15:0]};
				else
					next_byp = {pix_s2[15:0], held[15:8]};
			end
			default:
				next_valid = 1'b1;
		endcase
	end

	// Framing counters and first-stage registers
	always @(posedge sys_clk)
	begin
		if (reset)
		begin
			blank_prev <= 1'b0;
			phase <= 1'b0;
			pk_cnt <= 2'd0;
			held <= 16'h0000;
			index1 <= {AW{1'b0}};
			byp1 <= 24'h000000;
			byp_sel1 <= 1'b0;
			blank1 <= 1'b0;
		end
		else
		begin
			blank_prev <= blank_s2;
			if (blank_rise)
			begin
				phase <= 1'b1;
				pk_cnt <= 2'd1;
			end
			else
			begin
				phase <= ~phase;
				if (pk_cnt == 2'd2)
					pk_cnt <= 2'd0;
				else
					pk_cnt <= pk_cnt + 2'd1;
			end
			held <= (mode == `MODE_BYP24_B && cur_cnt == 2'd1) ?
				{pix_s2[7:0], held[7:0]} : pix_s2;
			index1 <= next_index;
			byp_sel1 <= (mode != `MODE_PSEUDO8) && (mode != `MODE_PSEUDO16);
			if (next_valid)
				byp1 <= next_byp;
			blank1 <= blank_s2;
		end
	end

	palette_ram #(.ENTRIES(ENTRIES), .AW(AW), .DW(3*CW)) u_palette (
		.sys_clk(sys_clk),
		.wr_en(pal_wr_en),
		.wr_addr(pal_wr_addr),
		.wr_data(pal_wr_data),
		.rd_addr(index1),
		.rd_data(pal_q)
	);

	// Second stage, aligned with the palette read
	always @(posedge sys_clk)
	begin
		if (reset)
		begin
			byp2 <= 24'h000000;
			byp_sel2 <= 1'b0;
			blank2 <= 1'b0;
		end
		else
		begin
			byp2 <= byp1;
			byp_sel2 <= byp_sel1;
			blank2 <= blank1;
		end
	end

	// Output stage: third edge drives the DACs
	always @(posedge sys_clk)
	begin
		if (reset)
		begin
			dac_red <= {DACW{1'b0}};
			dac_green <= {DACW{1'b0}};
			dac_blue <= {DACW{1'b0}};
			dac_power_down <= 1'b1;
			sense_n <= 1'b1;
			video_mode <= `MODE_PSEUDO8;
		end
		else
		begin
			video_mode <= mode;
			dac_power_down <= ~blank2;
			if (!blank2)
			begin
				dac_red <= {DACW{1'b0}};
				dac_green <= {DACW{1'b0}};
				dac_blue <= {DACW{1'b0}};
			end
			else if (byp_sel2)
			begin
				dac_red <= byp2[23:16];
				dac_green <= byp2[15:8];
				dac_blue <= byp2[7:0];
			end
			else
			begin
				dac_red <= widen({2'h0, pal_q[3*CW-1:2*CW]}, 4'd6);
				dac_green <= widen({2'h0, pal_q[2*CW-1:CW]}, 4'd6);
				dac_blue <= widen({2'h0, pal_q[CW-1:0]}, 4'd6);
			end
			sense_n <= ~(|comp_s2);
		end
	end
endmodule // palette_pixel_pipeline

// ===== palette_pixel_pipeline_properties.sv
// Checker for the pixel pipeline ports
`timescale 1ns/1ns
module pipe_checker
(
	input wire sys_clk,
	input wire reset,
	input wire [15:0] pixel_bus,
	input wire blank_n,
	input wire [7:0] command,
	input wire [7:0] pixel_mask,
	input wire pal_wr_en,
	input wire [2:0] comp_above,
	input wire [7:0] dac_red,
	input wire [7:0] dac_green,
	input wire [7:0] dac_blue,
	input wire dac_power_down,
	input wire sense_n,
	input wire [3:0] video_mode
);
	reg [2:0] up; // Edges since reset
	reg [2:0] q; // Edges with quiet inputs
	reg [24:0] prev; // Last input sample
	wire [24:0] cur = {pixel_bus[7:0], blank_n, command, pixel_mask};
	wire [23:0] rgb = {dac_red, dac_green, dac_blue};
	// Saturating run counters
	always @(posedge sys_clk)
	begin
		prev <= cur;
		up <= reset ? 3'h0 : (up == 3'h7 ? up : up + 3'h1);
		q <= (reset || cur != prev || pal_wr_en) ? 3'h0 : (q == 3'h7 ? q : q + 3'h1);
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);
	property p_rst;
		disable iff (1'b0) reset |=> dac_power_down && sense_n && video_mode == 4'h0;
	endproperty
	a_rst: assert property (p_rst) else $error("reset values wrong");
	property p_pd;
		up == 3'h7 |-> dac_power_down == !$past(blank_n, 5);
	endproperty
	a_pd: assert property (p_pd) else $error("blank delay wrong");
	property p_dark;
		dac_power_down |-> rgb == 24'h000000;
	endproperty
	a_dark: assert property (p_dark) else $error("dac not dark");
	property p_mode;
		up == 3'h7 && $past(command[7:4], 3) <= 4'h8 |-> video_mode == $past(command[7:4], 3);
	endproperty
	a_mode: assert property (p_mode) else $error("mode select wrong");
	property p_slo;
		up == 3'h7 && $past(comp_above, 3) != 3'h0 |-> !sense_n;
	endproperty
	a_slo: assert property (p_slo) else $error("sense not low");
	property p_shi;
		up == 3'h7 && $past(comp_above, 3) == 3'h0 |-> sense_n;
	endproperty
	a_shi: assert property (p_shi) else $error("sense not high");
	property p_idx;
		q == 3'h7 && video_mode == 4'h0 |-> $stable(rgb);
	endproperty
	a_idx: assert property (p_idx) else $error("lookup unsteady");
	property p_byte;
		q == 3'h7 && video_mode > 4'h0 && video_mode < 4'h4 |-> $stable(rgb);
	endproperty
	a_byte: assert property (p_byte) else $error("upper byte leaked");
	c_blank: cover property (up == 3'h7 && dac_power_down);
	c_sns: cover property (!sense_n);
	c_idx: cover property (q == 3'h7 && video_mode == 4'h0 && !dac_power_down);
endmodule // pipe_checker
bind palette_pixel_pipeline pipe_checker pipe_checker_i (.sys_clk, .reset, .pixel_bus,
	.blank_n, .command, .pixel_mask, .pal_wr_en, .comp_above, .dac_red, .dac_green,
	.dac_blue, .dac_power_down, .sense_n, .video_mode);

// ===== pixel_source.sv
// Graphics controller model driving pixels and blanking
`timescale 1ns/1ns
module pixel_source
(
	input wire [15:0] pix_req,
	input wire blank_req,
	output logic [15:0] pixel_bus,
	output logic blank_n
);
	always @*
	begin
		pixel_bus = pix_req;
		blank_n = blank_req;
	end
endmodule // pixel_source

// ===== tb_top.sv
// Testbench for the pixel pipeline
`timescale 1ns/1ns
module tb_top;
	reg sys_clk = 1'b0;
	reg reset = 1'b1;
	reg [15:0] pix_req = 16'h0000;
	reg blank_req = 1'b0;
	reg [7:0] command = 8'h00;
	reg [7:0] pixel_mask = 8'hFF;
	reg pal_wr_en = 1'b0;
	reg [7:0] pal_wr_addr = 8'h00;
	reg [17:0] pal_wr_data = 18'h00000;
	reg [2:0] comp_above = 3'h0;
	wire [15:0] pixel_bus;
	wire blank_n;
	wire [7:0] dac_red;
	wire [7:0] dac_green;
	wire [7:0] dac_blue;
	wire dac_power_down;
	wire sense_n;
	wire [3:0] video_mode;
	integer num_errors = 0;
	integer n_checks = 0;
	integer m;
	// Pixel clock, 50 ns
	always #25 sys_clk = ~sys_clk;
	pixel_source pixel_source_i (.pix_req, .blank_req, .pixel_bus, .blank_n);
	palette_pixel_pipeline palette_pixel_pipeline_i (.sys_clk, .reset, .pixel_bus, .blank_n,
		.command, .pixel_mask, .pal_wr_en, .pal_wr_addr, .pal_wr_data, .comp_above,
		.dac_red, .dac_green, .dac_blue, .dac_power_down, .sense_n, .video_mode);
	task chk(input string nm, input logic [23:0] e, input logic [23:0] g);
	begin
		n_checks = n_checks + 1;
		if (g !== e)
		begin
			num_errors = num_errors + 1;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	end
	endtask
	task cyc(input integer n);
		repeat (n) @(negedge sys_clk);
	endtask
	task pal_wr(input [7:0] a, input [17:0] d);
	begin
		pal_wr_en = 1'b1;
		pal_wr_addr = a;
		pal_wr_data = d;
		cyc(1);
		pal_wr_en = 1'b0;
		cyc(4);
	end
	endtask
	task t_rst;
	begin
		chk("mode", 24'h0, video_mode);
		chk("power", 24'h1, dac_power_down);
		chk("dac", 24'h0, {dac_red, dac_green, dac_blue});
		$display("test reset done");
	end
	endtask
	task t_pal;
	begin
		pal_wr(8'h35, {6'h2A, 6'h15, 6'h3F});
		pal_wr(8'h3F, {6'h01, 6'h02, 6'h03});
		blank_req = 1'b1;
		pix_req = 16'hC03F;
		pixel_mask = 8'hF5;
		cyc(8);
		chk("lut", 24'hAA55FF, {dac_red, dac_green, dac_blue});
		chk("power", 24'h0, dac_power_down);
		pixel_mask = 8'hFF;
		cyc(8);
		chk("lut", 24'h04080C, {dac_red, dac_green, dac_blue});
		$display("test palette done");
	end
	endtask
	task t_blank;
	begin
		blank_req = 1'b0;
		cyc(8);
		chk("power", 24'h1, dac_power_down);
		chk("dac", 24'h0, {dac_red, dac_green, dac_blue});
		blank_req = 1'b1;
		cyc(8);
		chk("power", 24'h0, dac_power_down);
		$display("test blank done");
	end
	endtask
	task t_sense;
	begin
		for (m = 0; m < 3; m = m + 1)
		begin
			comp_above = 3'h1 << m;
			cyc(6);
			chk("sense", 24'h0, sense_n);
			comp_above = 3'h0;
			cyc(6);
			chk("sense", 24'h1, sense_n);
		end
		$display("test sense done");
	end
	endtask
	task t_byp;
	begin
		command = 8'h60;
		pix_req = 16'hF81F;
		cyc(10);
		chk("byp16w", 24'hFF00FF, {dac_red, dac_green, dac_blue});
		command = 8'h20;
		blank_req = 1'b0;
		cyc(6);
		blank_req = 1'b1;
		for (m = 0; m < 10; m = m + 1)
		begin
			pix_req = m[0] ? 16'h55F8 : 16'hAA1F;
			cyc(1);
		end
		chk("byp16b", 24'hFF00FF, {dac_red, dac_green, dac_blue});
		command = 8'h00;
		pix_req = 16'hC03F;
		cyc(8);
		$display("test bypass done");
	end
	endtask
	task t_mode;
	begin
		for (m = 0; m < 9; m = m + 1)
		begin
			command = {m[3:0], 4'h0};
			cyc(10);
			pix_req[15:8] = ~pix_req[15:8];
			cyc(10);
			chk("mode", m[23:0], video_mode);
		end
		$display("test mode done");
	end
	endtask
	task print_verdict;
	begin
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	end
	endtask
	// Main sequence
	initial
	begin
		cyc(8);
		reset = 1'b0;
		cyc(1);
		t_rst;
		t_pal;
		t_blank;
		t_sense;
		t_byp;
		t_mode;
		print_verdict;
	end
endmodule // tb_top
